// *** bench/dcsec_ctrl_sva.sv ***
/* Port assertions for dcsec_ctrl.
   Assumes clk_en drops only while the outputs are steady. */
`timescale 1ns/1ps
module dcsec_ctrl_chk (
	input wire        sys_clk,
	input wire        reset,
	input wire        enable_channel_one,
	input wire        enable_channel_two,
	input wire        start_request_input,
	input wire        auto_start_bridge,
	input wire [1:0]  connector_variant,
	input wire        reg_read,
	input wire [31:0] reg_rdata,
	input wire        valve_pressurise,
	input wire        feedback_closed,
	input wire        fault_lamp
);
	reg       seen_fault;
	reg [7:0] since_rel;
	reg [2:0] age;
	wire      same = connector_variant == 2'h0;
	wire      c1 = enable_channel_one;
	wire      c2 = enable_channel_two;
	wire      press_lvl = same ? c1 & c2 : ~c1 & c2;
	wire      exh_lvl = same ? ~c1 & ~c2 : c1 & ~c2;
	// Early cycles after reset still see the previous pin setup
	always @(posedge sys_clk) begin
		if (reset) begin
			seen_fault <= 1'b0;
			since_rel <= 8'hff;
			age <= 3'h0;
		end else begin
			seen_fault <= seen_fault | fault_lamp;
			age <= (age == 3'h7) ? age : age + 3'h1;
			if (start_request_input)
				since_rel <= 8'h00;
			else if (since_rel != 8'hff)
				since_rel <= since_rel + 8'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_lamp_exhausts: assert property (
		fault_lamp |-> !valve_pressurise) else $error("lamp while pressurised");
	a_fault_latch: assert property (
		seen_fault |-> !valve_pressurise && !feedback_closed)
		else $error("fault state left");
	a_fb_open_press: assert property (
		feedback_closed |-> !valve_pressurise) else $error("contact closed");
	a_press_needs_en: assert property (
		$rose(valve_pressurise) |-> $past(press_lvl, 4))
		else $error("pressurised without enables");
	a_fb_needs_exh: assert property (
		$rose(feedback_closed) && age == 3'h7 && connector_variant != 2'h2
		|-> $past(exh_lvl, 4)) else $error("contact closed early");
	a_start_gate: assert property (
		$rose(valve_pressurise) && !auto_start_bridge |-> since_rel < 8'd30)
		else $error("pressurised without start");
	a_iso_no_fault: assert property (
		connector_variant == 2'h2 |-> !fault_lamp) else $error("isolated fault");
	a_rdata_idle: assert property (
		!$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
endmodule
bind dcsec_ctrl dcsec_ctrl_chk u_chk (.sys_clk(sys_clk), .reset(reset),
	.enable_channel_one(enable_channel_one),
	.enable_channel_two(enable_channel_two),
	.start_request_input(start_request_input),
	.auto_start_bridge(auto_start_bridge),
	.connector_variant(connector_variant), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .valve_pressurise(valve_pressurise),
	.feedback_closed(feedback_closed), .fault_lamp(fault_lamp));

// *** bench/dcsec_ctrl_tb_top.sv ***
/* Testbench for dcsec_ctrl: register tasks and pin scenarios.
   Assumes the relay model and the bound checker. */
`timescale 1ns/1ps
module dcsec_ctrl_tb_top;
	reg         sys_clk = 1'b0, reset = 1'b1, start = 1'b0, bridge = 1'b1;
	reg  [1:0]  variant = 2'h0, cmd = 2'h0;
	reg  [3:0]  addr = 4'h0;
	reg  [31:0] wdata = 32'h0;
	reg         wr_s = 1'b0, rd_s = 1'b0, go = 1'b0, run = 1'b1;
	reg  [7:0]  plen = 8'h00;
	wire        ch1, ch2, irq, valve, fb, lamp;
	wire [31:0] rdata;
	integer     n_fail = 0, compares = 0;
	// Sim-sized timing; a real build keeps the default counts
	localparam integer T_MIN = 10, T_MAX = 100, T_DLY = 50, T_EXH = 3;
	localparam integer T_PRS = 12, T_SKEW = 40, T_BLINK = 8;
	initial forever #20 sys_clk = ~sys_clk;
	dcsec_relay_model rly (.sys_clk(sys_clk), .variant(variant), .cmd(cmd),
		.pulse_len(plen), .pulse_go(go), .ch_one(ch1), .ch_two(ch2));
	dcsec_ctrl #(.START_MIN_CYC(T_MIN), .START_MAX_CYC(T_MAX),
		.START_DELAY_CYC(T_DLY), .PULSE_EXH_CYC(T_EXH),
		.PULSE_PRESS_CYC(T_PRS), .SKEW_CYC(T_SKEW),
		.BLINK_CYC(T_BLINK)) uut (.sys_clk(sys_clk), .reset(reset),
		.clk_en(run), .enable_channel_one(ch1), .enable_channel_two(ch2),
		.start_request_input(start), .auto_start_bridge(bridge),
		.connector_variant(variant), .reg_addr(addr), .reg_wdata(wdata),
		.reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .irq(irq),
		.valve_pressurise(valve), .feedback_closed(fb), .fault_lamp(lamp));
	task wrap_up;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	function [31:0] ov(input integer k);
		ov = {31'h0, k == 0 ? valve : k == 1 ? fb : k == 2 ? lamp : irq};
	endfunction
	task cyc(input integer n);
		repeat (n) @(posedge sys_clk);
	endtask
	task ob(input integer k, input v, input string nm);
		begin
			@(negedge sys_clk);
			chk(nm, {31'h0, v}, ov(k));
		end
	endtask
	task wt(input integer k, input v, input integer n);
		integer i;
		begin
			i = 0;
			while (ov(k) !== {31'h0, v} && i < n) begin
				@(negedge sys_clk);
				i = i + 1;
			end
			if (i >= n) begin
				n_fail = n_fail + 1;
				$display("[ERR] wait %0d exp %b got timeout", k, v);
				wrap_up;
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			addr <= a;
			wdata <= d;
			wr_s <= 1'b1;
			@(posedge sys_clk);
			wr_s <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [31:0] exp, input string nm);
		begin
			@(posedge sys_clk);
			addr <= a;
			rd_s <= 1'b1;
			@(posedge sys_clk);
			rd_s <= 1'b0;
			@(negedge sys_clk);
			chk(nm, exp, rdata);
		end
	endtask
	task sc(input [1:0] c);
		begin
			@(posedge sys_clk);
			cmd <= c;
		end
	endtask
	task tp(input [7:0] n);
		begin
			@(posedge sys_clk);
			go <= 1'b1;
			plen <= n;
			@(posedge sys_clk);
			go <= 1'b0;
			cyc(40);
		end
	endtask
	task sp(input integer w);
		begin
			@(posedge sys_clk);
			start <= 1'b1;
			cyc(w);
			start <= 1'b0;
			cyc(10);
		end
	endtask
	task rst(input [1:0] v, input b);
		begin
			@(posedge sys_clk);
			reset <= 1'b1;
			variant <= v;
			bridge <= b;
			cmd <= 2'h0;
			cyc(2);
			reset <= 1'b0;
			cyc(12);
		end
	endtask
	initial begin
		cyc(2);
		reset <= 1'b0;
		cyc(12);
		rd(4'h0, 32'h0, "status");
		rd(4'h8, 32'h10, "state");
		wr(4'h4, 32'h4);
		wr(4'hc, 32'h7);
		rd(4'h4, 32'h4, "mask");
		rd(4'hc, 32'h0, "unmapped");
		sc(2'h1);
		wt(0, 1'b1, 40);
		ob(1, 1'b0, "fb_press");
		rd(4'h0, 32'h1, "status");
		rd(4'h0, 32'h0, "status_rc");
		tp(8'h08);
		ob(0, 1'b1, "pulse_press");
		// Frozen clock enable: new channel levels must not act yet
		@(posedge sys_clk);
		run <= 1'b0;
		sc(2'h0);
		cyc(30);
		ob(0, 1'b1, "frozen_valve");
		ob(1, 1'b0, "frozen_fb");
		@(posedge sys_clk);
		run <= 1'b1;
		wt(1, 1'b1, 40);
		tp(8'h02);
		ob(1, 1'b1, "pulse_exh");
		ob(3, 1'b0, "irq_masked");
		sc(2'h2);
		wt(2, 1'b1, 200);
		ob(3, 1'b1, "irq");
		rd(4'h0, 32'h6, "status");
		ob(3, 1'b0, "irq_clr");
		sc(2'h1);
		cyc(60);
		ob(0, 1'b0, "latched");
		$display("test same_level done");
		rst(2'h2, 1'b1);
		sc(2'h2);
		cyc(80);
		ob(2, 1'b0, "iso_equal");
		rd(4'h8, 32'h5c, "state");
		sc(2'h1);
		wt(0, 1'b1, 40);
		sc(2'h2);
		wt(0, 1'b0, 40);
		cyc(60);
		ob(2, 1'b0, "iso_nofault");
		$display("test isolated done");
		rst(2'h1, 1'b0);
		sc(2'h1);
		cyc(20);
		sp(20);
		cyc(60);
		sp(5);
		ob(0, 1'b0, "start_gate");
		sp(20);
		wt(0, 1'b1, 40);
		rd(4'h0, 32'h19, "status");
		sc(2'h2);
		wt(2, 1'b1, 200);
		ob(0, 1'b0, "cross_exh");
		$display("test monitored done");
		rst(2'h0, 1'b1);
		sc(2'h1);
		wt(0, 1'b1, 40);
		sp(120);
		ob(0, 1'b0, "stuck_start");
		$display("test stuck_start done");
		rst(2'h3, 1'b1);
		sc(2'h1);
		cyc(40);
		ob(0, 1'b0, "var3_valve");
		ob(2, 1'b0, "var3_lamp");
		$display("test spare_variant done");
		wrap_up;
	end
endmodule

// *** bench/dcsec_relay_model.sv ***
/* Safety relay model: drives both enable channels from a command.
   Assumes command and variant change by NBA after a clock edge. */
`timescale 1ns/1ps
module dcsec_relay_model (
	input  wire       sys_clk,
	input  wire [1:0] variant,
	input  wire [1:0] cmd,
	input  wire [7:0] pulse_len,
	input  wire       pulse_go,
	output wire       ch_one,
	output wire       ch_two
);
	reg [7:0] left = 8'h00;
	wire      same = variant == 2'h0;
	// Command 2 drives channel one high: a mismatch in same-level, a short between the channels otherwise
	wire      one_lvl = cmd == 2'h2 || (same ? cmd == 2'h1 : cmd == 2'h0);
	wire      two_lvl = same ? cmd == 2'h1 : cmd != 2'h0;
	// Clocked test pulse inverts channel one
	always @(posedge sys_clk) begin
		if (pulse_go)
			left <= pulse_len;
		else if (left != 8'h00)
			left <= left - 8'h01;
	end
	assign ch_one = one_lvl ^ (left != 8'h00);
	assign ch_two = two_lvl;
endmodule

// *** include/dcsec_regs.vh ***
/*
 * Constants of the dual-channel safety enable control: register offsets,
 * field positions, reset values, connector variant codes and timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DCSEC_REGS_VH
`define DCSEC_REGS_VH

`define DCSEC_CLK_KHZ         25000

`define DCSEC_START_MIN_MS    100
`define DCSEC_START_MAX_MS    2000
`define DCSEC_START_DELAY_MS  1000
`define DCSEC_PULSE_EXH_MS    3
`define DCSEC_PULSE_PRESS_MS  12
`define DCSEC_SKEW_MS         20
`define DCSEC_BLINK_MS        250

`define DCSEC_OFF_STATUS      4'h0
`define DCSEC_OFF_MASK        4'h4
`define DCSEC_OFF_STATE       4'h8

`define DCSEC_EV_PRESS        0
`define DCSEC_EV_EXHAUST      1
`define DCSEC_EV_FAULT        2
`define DCSEC_EV_START_REJ    3
`define DCSEC_EV_START_ACC    4
`define DCSEC_EV_W            5

`define DCSEC_ST_STATE_LSB    0
`define DCSEC_ST_CH_ONE       2
`define DCSEC_ST_CH_TWO       3
`define DCSEC_ST_AUTO         4
`define DCSEC_ST_VARIANT_LSB  5

`define DCSEC_MASK_RESET      5'h00

`define DCSEC_VAR_SAME        2'h0
`define DCSEC_VAR_OPP_MON     2'h1
`define DCSEC_VAR_OPP_ISO     2'h2

`endif

// *** verilog/dcsec_chan_filter.v ***
/*
 * One enable channel: two-flop synchroniser, then a pulse filter that lets
 * a level change through only after it has held for limit cycles.
 * Assumes limit is at least 1 and comes from logic on sys_clk.
 */
`timescale 1ns/1ps

module dcsec_chan_filter (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        raw_in,
	input  wire [19:0] limit,
	output reg         level_out
);

	reg        sync_a;
	reg        sync_b;
	reg [19:0] hold_cnt;

	always @(posedge sys_clk) begin
		if (reset) begin
			sync_a    <= 1'b0;
			sync_b    <= 1'b0;
			hold_cnt  <= 20'h00000;
			level_out <= 1'b0;
		end else if (clk_en) begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			// Short test pulses die here and never reach the decoder
			if (sync_b == level_out) begin
				hold_cnt <= 20'h00000;
			end else if (hold_cnt + 20'h00001 >= limit) begin
				hold_cnt  <= 20'h00000;
				level_out <= sync_b;
			end else begin
				hold_cnt <= hold_cnt + 20'h00001;
			end
		end
	end

endmodule

// *** verilog/dcsec_ctrl.v ***
/*
 * Control logic of a redundant safety valve: enable channel decoding for
 * three connector variants, start-button supervision, latched fault mode,
 * feedback contact, fault lamp and a small register port with interrupt.
 * Assumes all pins are asynchronous to sys_clk; the register port is
 * driven from sys_clk logic. Fault mode leaves only through reset.
 */
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "dcsec_regs.vh"

// Operation
// - Bridge present selects automatic start mode
// - Valid enables never override the start request; a stuck start still faults despite valid enables
// - Start pulse accepted only within 0.1-2 s
// - Start held beyond maximum means fault mode
// - Start must follow valid enables by 1 s
// - Same-level: low exhausts, high pressurises, mismatch faults
// - Monitored opposite: one-low two-high pressurises; equal faults
// - Isolated opposite: equal levels exhaust, no fault
// - Exhausted: ignore test pulses under 3 ms
// - Pressurised: ignore test pulses under 12 ms
// - Monitored opposite: channel skew violation is fault
// - Cross circuit: exhaust and enter malfunction
// - Isolated: no skew or cross check
// - Isolated: removed enables exhaust without malfunction
// - Same-level: out-of-limit test pulse switches off safely
// - Feedback closed only while channels command exhaust
module dcsec_ctrl #(
	parameter START_MIN_CYC   = `DCSEC_START_MIN_MS * `DCSEC_CLK_KHZ,
	parameter START_MAX_CYC   = `DCSEC_START_MAX_MS * `DCSEC_CLK_KHZ,
	parameter START_DELAY_CYC = `DCSEC_START_DELAY_MS * `DCSEC_CLK_KHZ,
	parameter PULSE_EXH_CYC   = `DCSEC_PULSE_EXH_MS * `DCSEC_CLK_KHZ,
	parameter PULSE_PRESS_CYC = `DCSEC_PULSE_PRESS_MS * `DCSEC_CLK_KHZ,
	parameter SKEW_CYC        = `DCSEC_SKEW_MS * `DCSEC_CLK_KHZ,
	parameter BLINK_CYC       = `DCSEC_BLINK_MS * `DCSEC_CLK_KHZ
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        enable_channel_one,
	input  wire        enable_channel_two,
	input  wire        start_request_input,
	input  wire        auto_start_bridge,
	input  wire [1:0]  connector_variant,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [31:0] reg_rdata,
	output wire        irq,
	output reg         valve_pressurise,
	output reg         feedback_closed,
	output reg         fault_lamp
);

	localparam ST_EXHAUST  = 2'h0;
	localparam ST_PRESSURE = 2'h1;
	localparam ST_FAULT    = 2'h2;

	localparam [25:0] C_START_MIN = START_MIN_CYC[25:0];
	localparam [25:0] C_START_MAX = START_MAX_CYC[25:0];
	localparam [25:0] C_DELAY     = START_DELAY_CYC[25:0];
	localparam [25:0] C_SKEW      = SKEW_CYC[25:0];
	localparam [25:0] C_BLINK     = BLINK_CYC[25:0];
	localparam [19:0] C_PULSE_EXH = PULSE_EXH_CYC[19:0];
	localparam [19:0] C_PULSE_PRS = PULSE_PRESS_CYC[19:0];

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	wire [1:0]  chan_raw;
	wire [1:0]  chan_lvl;
	wire [19:0] pulse_limit;

	wire [3:0]  pin_raw;
	wire [3:0]  pin_lvl;
	reg         start_prev;

	reg  [25:0] en_cnt;
	reg  [25:0] width_cnt;
	reg  [25:0] skew_cnt;
	reg  [25:0] blink_cnt;
	reg         start_armed;

	reg  [`DCSEC_EV_W-1:0] status;
	reg  [`DCSEC_EV_W-1:0] mask;
	reg  [`DCSEC_EV_W-1:0] events;

	reg cmd_press;
	reg cmd_exhaust;
	reg cmd_bad;

	wire start_lvl  = pin_lvl[0];
	wire auto_mode  = pin_lvl[1];
	wire [1:0] variant = pin_lvl[3:2];
	wire start_rise = start_lvl & ~start_prev;
	wire start_fall = ~start_lvl & start_prev;
	wire isolated   = (variant == `DCSEC_VAR_OPP_ISO);

	assign chan_raw = {enable_channel_two, enable_channel_one};
	// Longer tolerance while pressurised avoids dropping out on test pulses
	assign pulse_limit = (state == ST_PRESSURE) ? C_PULSE_PRS
	                                            : C_PULSE_EXH;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
			dcsec_chan_filter u_filter (
				.sys_clk   (sys_clk),
				.reset     (reset),
				.clk_en    (clk_en),
				.raw_in    (chan_raw[gi]),
				.limit     (pulse_limit),
				.level_out (chan_lvl[gi])
			);
		end
	endgenerate

	// Every strap and button pin crosses two flops before logic reads it
	assign pin_raw = {connector_variant, auto_start_bridge,
	                  start_request_input};

	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
			reg sync_a;
			reg sync_b;
			always @(posedge sys_clk) begin
				if (reset) begin
					sync_a <= 1'b0;
					sync_b <= 1'b0;
				end else if (clk_en) begin
					sync_a <= pin_raw[gi];
					sync_b <= sync_a;
				end
			end
			assign pin_lvl[gi] = sync_b;
		end
	endgenerate

	// Decoding of the filtered channel pair per connector variant
	always @* begin
		cmd_press   = 1'b0;
		cmd_exhaust = 1'b0;
		cmd_bad     = 1'b0;
		case (variant)
		`DCSEC_VAR_SAME: begin
			cmd_press   = chan_lvl[0] & chan_lvl[1];
			cmd_exhaust = ~chan_lvl[0] & ~chan_lvl[1];
			cmd_bad     = chan_lvl[0] ^ chan_lvl[1];
		end
		`DCSEC_VAR_OPP_MON: begin
			cmd_press   = ~chan_lvl[0] & chan_lvl[1];
			cmd_exhaust = chan_lvl[0] & ~chan_lvl[1];
			cmd_bad     = ~(chan_lvl[0] ^ chan_lvl[1]);
		end
		`DCSEC_VAR_OPP_ISO: begin
			// Equal levels read as exhaust; the upstream unit owns cross checks
			cmd_press   = ~chan_lvl[0] & chan_lvl[1];
			cmd_exhaust = ~cmd_press;
		end
		default: begin
			cmd_exhaust = 1'b1;
		end
		endcase
	end

	wire skew_fault  = ~isolated & (skew_cnt >= C_SKEW);
	wire width_fault = (width_cnt > C_START_MAX);
	wire start_ok    = start_fall & start_armed & cmd_press
	                 & (width_cnt >= C_START_MIN);
	wire start_rej   = (start_rise & (en_cnt < C_DELAY))
	                 | (start_fall & start_armed
	                    & (width_cnt < C_START_MIN));

	always @* begin
		next_state = state;
		case (state)
		ST_EXHAUST: begin
			if (skew_fault | width_fault) begin
				next_state = ST_FAULT;
			end else if (cmd_press & (auto_mode | start_ok)) begin
				next_state = ST_PRESSURE;
			end
		end
		ST_PRESSURE: begin
			if (skew_fault | width_fault) begin
				next_state = ST_FAULT;
			end else if (~cmd_press) begin
				next_state = ST_EXHAUST;
			end
		end
		ST_FAULT: begin
			next_state = ST_FAULT;
		end
		default: begin
			next_state = ST_FAULT;
		end
		endcase
	end

	always @* begin
		events = {`DCSEC_EV_W{1'b0}};
		events[`DCSEC_EV_PRESS] = (next_state == ST_PRESSURE)
		                        & (state != ST_PRESSURE);
		events[`DCSEC_EV_EXHAUST] = (next_state == ST_EXHAUST)
		                          & (state == ST_PRESSURE);
		events[`DCSEC_EV_FAULT] = (next_state == ST_FAULT)
		                        & (state != ST_FAULT);
		events[`DCSEC_EV_START_REJ] = ~auto_mode & start_rej;
		events[`DCSEC_EV_START_ACC] = ~auto_mode & start_ok;
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			start_prev <= 1'b0;
			state      <= ST_EXHAUST;
		end else if (clk_en) begin
			start_prev <= start_lvl;
			state      <= next_state;
		end
	end

	// Time since the enables became valid, saturating
	always @(posedge sys_clk) begin
		if (reset) begin
			en_cnt <= 26'h0000000;
		end else if (clk_en) begin
			if (~cmd_press) begin
				en_cnt <= 26'h0000000;
			end else if (en_cnt < C_DELAY) begin
				en_cnt <= en_cnt + 26'h0000001;
			end
		end
	end

	// Width of the start pulse, also catches a stuck button
	always @(posedge sys_clk) begin
		if (reset) begin
			width_cnt <= 26'h0000000;
		end else if (clk_en) begin
			if (~start_lvl) begin
				width_cnt <= 26'h0000000;
			end else if (~width_fault) begin
				width_cnt <= width_cnt + 26'h0000001;
			end
		end
	end

	// Edge before the 1 s mark is dropped; new press needed
	always @(posedge sys_clk) begin
		if (reset) begin
			start_armed <= 1'b0;
		end else if (clk_en) begin
			if (~cmd_press | start_fall) begin
				start_armed <= 1'b0;
			end else if (start_rise) begin
				start_armed <= (en_cnt >= C_DELAY);
			end
		end
	end

	// Transient disagreement is tolerated for the skew window only
	always @(posedge sys_clk) begin
		if (reset) begin
			skew_cnt <= 26'h0000000;
		end else if (clk_en) begin
			if (~cmd_bad | isolated) begin
				skew_cnt <= 26'h0000000;
			end else if (~skew_fault) begin
				skew_cnt <= skew_cnt + 26'h0000001;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			valve_pressurise <= 1'b0;
			feedback_closed  <= 1'b0;
		end else if (clk_en) begin
			valve_pressurise <= (next_state == ST_PRESSURE);
			feedback_closed  <= (next_state == ST_EXHAUST)
			                  & cmd_exhaust;
		end
	end

	// Lamp blinks while latched in fault, dark otherwise
	always @(posedge sys_clk) begin
		if (reset) begin
			fault_lamp <= 1'b0;
			blink_cnt  <= 26'h0000000;
		end else if (clk_en) begin
			if (next_state != ST_FAULT) begin
				blink_cnt  <= 26'h0000000;
				fault_lamp <= 1'b0;
			end else if (blink_cnt + 26'h0000001 >= C_BLINK) begin
				blink_cnt  <= 26'h0000000;
				fault_lamp <= ~fault_lamp;
			end else begin
				blink_cnt <= blink_cnt + 26'h0000001;
			end
		end
	end

	// Register port; a status read clears, but a new event wins
	wire status_rd = reg_read & (reg_addr == `DCSEC_OFF_STATUS);

	always @(posedge sys_clk) begin
		if (reset) begin
			status <= {`DCSEC_EV_W{1'b0}};
			mask   <= `DCSEC_MASK_RESET;
		end else if (clk_en) begin
			if (status_rd) begin
				status <= events;
			end else begin
				status <= status | events;
			end
			if (reg_write & (reg_addr == `DCSEC_OFF_MASK)) begin
				mask <= reg_wdata[`DCSEC_EV_W-1:0];
			end
		end
	end

	// Read data stand for one cycle only and idle at zero
	always @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			reg_rdata <= 32'h00000000;
			if (reg_read) begin
				case (reg_addr)
				`DCSEC_OFF_STATUS: reg_rdata <= {27'h0, status};
				`DCSEC_OFF_MASK:   reg_rdata <= {27'h0, mask};
				`DCSEC_OFF_STATE:  reg_rdata <= {25'h0, variant, auto_mode,
				                                 chan_lvl, state};
				default:           reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign irq = |(status & mask);

endmodule
